/* File: pkg/mbx_defs.svh */
/*
 Constants for the host mailbox and external bus interface: access-mode
 field positions, reset values and timing counts. Included by bare name.
*/
`ifndef MBX_DEFS_SVH
`define MBX_DEFS_SVH

// ----------------------------------------------------------------------
// Access-mode register fields
// ----------------------------------------------------------------------
`define AMR_W            7
`define AMR_SPEED_BIT    0
`define AMR_ROLE_BIT     1
`define AMR_CONCAT_BIT   2
`define AMR_STROBE_BIT   3
`define AMR_ACK_BIT      4
`define AMR_BA_BIT       5
`define AMR_MASK_BIT     6
`define AMR_RESET_VAL    7'h04

// ----------------------------------------------------------------------
// Mailbox and timing
// ----------------------------------------------------------------------
`define MBX_DEPTH        3
`define OWNER_DSP        1'b0
`define OWNER_HOST       1'b1
`define SLOW_CYCLES      2

`endif

/* File: pkg/mbx_pkg.sv */
/*
 Types shared by the mailbox interface files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mbx_pkg;
   typedef enum logic [1:0] {
      LB_IDLE,
      LB_ACT,
      LB_HOLD
   } lbus_state_t;
endpackage : mbx_pkg

/* File: src/byte_shift_mbx.sv */
/*
 Three-byte shifting mailbox register. A push shifts a byte in at the tail,
 a pop shifts the head out. Assumes one clock and asynchronous reset.
*/
`include "mbx_defs.svh"
module byte_shift_mbx #(
   parameter int DEPTH = `MBX_DEPTH
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Control
   input  wire logic       i_push,
   input  wire logic [7:0] i_byte,
   input  wire logic       i_pop,
   // Head byte
   output logic      [7:0] o_head
);
   logic [7:0] bytes_ff [DEPTH];

   // ---------------------------------------------------------------
   // Shift stages
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               bytes_ff[g] <= 8'h00;
            end else if (i_push) begin
               if (g == DEPTH - 1) begin
                  bytes_ff[g] <= i_byte;
               end else begin
                  bytes_ff[g] <= bytes_ff[g + 1];
               end
            end else if (i_pop) begin
               // Head leaves, later bytes move forward
               if (g == DEPTH - 1) begin
                  bytes_ff[g] <= 8'h00;
               end else begin
                  bytes_ff[g] <= bytes_ff[g + 1];
               end
            end
         end
      end
   endgenerate

   assign o_head = bytes_ff[0];
endmodule : byte_shift_mbx

/* File: src/skid_buf2.sv */
/*
 Two-entry buffer with valid/ready on both sides. Assumes one clock and
 asynchronous reset; the drain side may stall indefinitely.
*/
module skid_buf2 #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Fill side
   input  wire logic             i_valid,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_ready,
   // Drain side
   output logic                  o_valid,
   output logic      [WIDTH-1:0] o_data,
   input  wire logic             i_ready
);
   logic [WIDTH-1:0] mem_ff [2];
   logic             wp_ff;
   logic             rp_ff;
   logic [1:0]       cnt_ff;
   logic             push;
   logic             pop;

   assign o_ready = (cnt_ff != 2'd2);
   assign o_valid = (cnt_ff != 2'd0);
   assign o_data  = mem_ff[rp_ff];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_ff[wp_ff] <= i_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wp_ff  <= 1'b0;
         rp_ff  <= 1'b0;
         cnt_ff <= 2'd0;
      end else begin
         if (push) begin
            wp_ff <= ~wp_ff;
         end
         if (pop) begin
            rp_ff <= ~rp_ff;
         end
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : skid_buf2

/* File: src/host_mailbox_if.sv */
/*
 External interface of the signal processor: host-side system bus with
 mailbox and ownership handshake, and the local bus controller.
 Assumes host pins are synchronous to i_clk and the core issues at most
 one local access at a time and honours o_core_halt.
*/
`include "mbx_defs.svh"
// Contract
// - Pseudo-slave drives low 8 RAM address bits on system pins, top 4 locally.
// - Host stays off system bus while device addresses RAM, unless granted.
// - Strobe mode: data strobe times transfer, separate read/write line.
// - Pulse mode: separate read and write pulses control local data.
// - Slow exchange stretches each local access to two machine cycles.
// - Local data may split into two 8-bit halves chosen by top address bits.
// - Four local address bits, extended by eight system pins for RAM.
// - Ownership flag: 0 means DSP owns mailbox, 1 means host owns it.
// - Only DSP sets ownership flag, only host clears it.
// - Branch logic may test flag; setup instruction sets it to 1.
// - Handshake output goes low in the same cycle the flag is set; o_mailbox_owner_flag here rises one cycle after o_handshake_n falls.
// - On request handshake returns high; host gets bus; pseudo-slave halts.
// - Host access with select 0, register select 1 clears ownership flag.
// - Internal halt stops program after current instruction, runs no-operation.
// - While halted no addresses are driven on system pins.
// - Host-to-DSP mailbox: three bytes, host writes, core reads upper byte.
// - DSP-to-host mailbox: three bytes, core loads, host reads, shifts.
// - Access mode can enable a bus-available output.
// - Access-mode register is seven bits, loaded by setup or save, readable.
// - Bus role bit: 0 slave, 1 pseudo-slave using system pins.
// - Slow mode repeats the transfer instruction; real arithmetic mode only.
module host_mailbox_if #(
   parameter int MBX_BYTES = `MBX_DEPTH
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Host system bus
   input  wire logic        i_chip_select_n,
   input  wire logic        i_register_select,
   input  wire logic        i_host_dir,
   input  wire logic        i_host_data_strobe_n,
   input  wire logic [7:0]  i_system_bus_pins,
   output logic      [7:0]  o_system_bus_pins,
   output logic             o_system_bus_oe_n,
   output logic             o_handshake_n,
   output logic             o_transfer_ack_n,
   output logic             o_bus_avail,
   // Core control
   input  wire logic        i_setup_instruction,
   input  wire logic        i_save_instruction,
   input  wire logic [6:0]  i_amr_data,
   input  wire logic        i_give_mailbox,
   input  wire logic        i_real_mode,
   input  wire logic        i_instr_done,
   output logic      [6:0]  o_access_mode_reg,
   output logic             o_mailbox_owner_flag,
   output logic             o_core_halt,
   output logic             o_repeat_instr,
   // Core mailbox data
   input  wire logic        i_mbx_rd,
   output logic      [7:0]  o_lbus_upper_byte,
   input  wire logic        i_mbx_wr,
   input  wire logic [7:0]  i_result_bus_upper_byte,
   // Core local access
   input  wire logic        i_acc_req,
   input  wire logic        i_acc_wr,
   input  wire logic [11:0] i_acc_addr,
   input  wire logic [15:0] i_acc_wdata,
   output logic             o_acc_busy,
   output logic             o_rd_valid,
   output logic      [15:0] o_rd_data,
   input  wire logic        i_rd_ready,
   // Local bus pins
   output logic      [3:0]  o_local_addr_pins,
   output logic      [15:0] o_local_data_pins,
   output logic      [1:0]  o_local_data_oe_n,
   input  wire logic [15:0] i_local_data_pins,
   output logic             o_local_data_strobe_n,
   output logic             o_local_rw,
   output logic             o_local_rd_n,
   output logic             o_local_wr_n
);
   // ---------------------------------------------------------------
   // Access mode
   // ---------------------------------------------------------------
   logic [6:0] amr_ff;
   logic       slow;
   logic       pseudo;
   logic       concat;
   logic       strobe_mode;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         amr_ff <= `AMR_RESET_VAL;
      end else if (i_setup_instruction || i_save_instruction) begin
         amr_ff <= i_amr_data;
      end
   end

   // Slow exchange is honoured only in real arithmetic mode
   assign slow        = amr_ff[`AMR_SPEED_BIT] && i_real_mode;
   assign pseudo      = amr_ff[`AMR_ROLE_BIT];
   assign concat      = amr_ff[`AMR_CONCAT_BIT];
   assign strobe_mode = amr_ff[`AMR_STROBE_BIT];

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_access_mode_reg <= `AMR_RESET_VAL;
      end else begin
         o_access_mode_reg <= amr_ff;
      end
   end

   // ---------------------------------------------------------------
   // Host strobe decode
   // ---------------------------------------------------------------
   logic strobe_d_ff;
   logic host_acc;
   logic bus_req;
   logic release_bus;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         strobe_d_ff <= 1'b1;
      end else begin
         strobe_d_ff <= i_host_data_strobe_n;
      end
   end

   // Act once on the falling strobe edge so a long strobe shifts one byte
   assign host_acc    = strobe_d_ff && !i_host_data_strobe_n && !i_chip_select_n;
   assign bus_req     = host_acc && !i_register_select && i_host_dir;
   assign release_bus = host_acc && i_register_select;

   // ---------------------------------------------------------------
   // Ownership flag, handshake and grant
   // ---------------------------------------------------------------
   logic owner_ff;
   logic grant_ff;
   logic set_owner;

   assign set_owner = i_setup_instruction && i_give_mailbox;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         owner_ff <= `OWNER_DSP;
      end else if (set_owner) begin
         owner_ff <= `OWNER_HOST;
      end else if (release_bus) begin
         owner_ff <= `OWNER_DSP;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_handshake_n <= 1'b1;
      end else if (set_owner) begin
         o_handshake_n <= 1'b0;
      end else if (bus_req) begin
         o_handshake_n <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         grant_ff <= 1'b0;
      end else if (bus_req && owner_ff == `OWNER_HOST) begin
         grant_ff <= 1'b1;
      end else if (release_bus) begin
         grant_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mailbox_owner_flag <= `OWNER_DSP;
      end else begin
         o_mailbox_owner_flag <= owner_ff;
      end
   end

   // ---------------------------------------------------------------
   // Internal halt
   // ---------------------------------------------------------------
   logic halt_ff;

   // Halt takes effect at an instruction boundary; core then runs no-operation
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         halt_ff <= 1'b0;
      end else if (grant_ff && pseudo && i_instr_done) begin
         halt_ff <= 1'b1;
      end else if (!grant_ff) begin
         halt_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_core_halt <= 1'b0;
      end else begin
         o_core_halt <= halt_ff;
      end
   end

   // ---------------------------------------------------------------
   // Mailboxes
   // ---------------------------------------------------------------
   logic [7:0] in_head;
   logic [7:0] out_head;

   byte_shift_mbx #(
      .DEPTH (MBX_BYTES)
   ) u_host_to_dsp_mailbox (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_push (host_acc && !i_register_select && !i_host_dir),
      .i_byte (i_system_bus_pins),
      .i_pop  (i_mbx_rd),
      .o_head (in_head)
   );

   byte_shift_mbx #(
      .DEPTH (MBX_BYTES)
   ) u_dsp_to_host_mailbox (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_push (i_mbx_wr),
      .i_byte (i_result_bus_upper_byte),
      .i_pop  (bus_req && owner_ff),
      .o_head (out_head)
   );

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_lbus_upper_byte <= 8'h00;
      end else begin
         o_lbus_upper_byte <= in_head;
      end
   end

   // ---------------------------------------------------------------
   // Local bus controller
   // ---------------------------------------------------------------
   mbx_pkg::lbus_state_t st_ff;
   logic [11:0]          addr_ff;
   logic [15:0]          wdata_ff;
   logic                 wr_ff;
   logic                 buf_ready;
   logic                 cap_ff;
   logic [15:0]          cap_data_ff;
   logic                 buf_valid;
   logic [15:0]          buf_data;
   logic [15:0]          rd_mask;

   // Read data cannot be stored while the buffer is full, so accesses wait
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= mbx_pkg::LB_IDLE;
      end else begin
         case (st_ff)
            mbx_pkg::LB_IDLE: begin
               if (i_acc_req && buf_ready && !halt_ff) begin
                  st_ff <= mbx_pkg::LB_ACT;
               end
            end
            mbx_pkg::LB_ACT: begin
               st_ff <= slow ? mbx_pkg::LB_HOLD : mbx_pkg::LB_IDLE;
            end
            mbx_pkg::LB_HOLD: begin
               st_ff <= mbx_pkg::LB_IDLE;
            end
            default: begin
               st_ff <= mbx_pkg::LB_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_ff  <= 12'h000;
         wdata_ff <= 16'h0000;
         wr_ff    <= 1'b0;
      end else if (st_ff == mbx_pkg::LB_IDLE && i_acc_req) begin
         addr_ff  <= i_acc_addr;
         wdata_ff <= i_acc_wdata;
         wr_ff    <= i_acc_wr;
      end
   end

   logic active;
   logic last;
   assign active = (st_ff == mbx_pkg::LB_IDLE) && i_acc_req && buf_ready && !halt_ff;
   assign last   = (st_ff == mbx_pkg::LB_ACT && !slow) || st_ff == mbx_pkg::LB_HOLD;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_local_data_strobe_n <= 1'b1;
         o_local_rw            <= 1'b1;
         o_local_rd_n          <= 1'b1;
         o_local_wr_n          <= 1'b1;
         o_local_addr_pins     <= 4'h0;
         o_local_data_pins     <= 16'h0000;
         o_local_data_oe_n     <= 2'b11;
         o_acc_busy            <= 1'b0;
         o_repeat_instr        <= 1'b0;
      end else if (active || (st_ff == mbx_pkg::LB_ACT && slow)) begin
         o_local_addr_pins <= active ? i_acc_addr[11:8] : addr_ff[11:8];
         o_local_data_pins <= active ? i_acc_wdata : wdata_ff;
         if (strobe_mode) begin
            o_local_data_strobe_n <= 1'b0;
            o_local_rw            <= active ? !i_acc_wr : !wr_ff;
         end else begin
            o_local_rd_n <= active ? i_acc_wr : wr_ff;
            o_local_wr_n <= active ? !i_acc_wr : !wr_ff;
         end
         // Split bus: upper address bits pick the half that is driven
         if (active ? i_acc_wr : wr_ff) begin
            if (concat) begin
               o_local_data_oe_n <= 2'b00;
            end else begin
               o_local_data_oe_n <= (active ? i_acc_addr[11] : addr_ff[11])
                                    ? 2'b01 : 2'b10;
            end
         end
         o_acc_busy     <= 1'b1;
         o_repeat_instr <= slow;
      end else begin
         o_local_data_strobe_n <= 1'b1;
         o_local_rw            <= 1'b1;
         o_local_rd_n          <= 1'b1;
         o_local_wr_n          <= 1'b1;
         o_local_data_oe_n     <= 2'b11;
         o_acc_busy            <= 1'b0;
         o_repeat_instr        <= 1'b0;
      end
   end

   // Capture read data at the end of the access window
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cap_ff      <= 1'b0;
         cap_data_ff <= 16'h0000;
      end else begin
         cap_ff      <= last && !wr_ff;
         cap_data_ff <= i_local_data_pins & rd_mask;
      end
   end

   assign rd_mask = concat ? 16'hffff : (addr_ff[11] ? 16'hff00 : 16'h00ff);

   skid_buf2 #(
      .WIDTH (16)
   ) u_rd_buf (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_valid (cap_ff),
      .i_data  (cap_data_ff),
      .o_ready (buf_ready),
      .o_valid (buf_valid),
      .o_data  (buf_data),
      .i_ready (i_rd_ready || !o_rd_valid)
   );

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_valid <= 1'b0;
         o_rd_data  <= 16'h0000;
      end else if (!o_rd_valid || i_rd_ready) begin
         o_rd_valid <= buf_valid;
         o_rd_data  <= buf_data;
      end
   end

   // ---------------------------------------------------------------
   // System bus pins
   // ---------------------------------------------------------------
   logic addr_on_sys;

   // System pins carry RAM address only in pseudo-slave, not granted, not halted
   assign addr_on_sys = pseudo && !grant_ff && !halt_ff;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_system_bus_pins <= 8'h00;
         o_system_bus_oe_n <= 1'b1;
         o_transfer_ack_n  <= 1'b1;
         o_bus_avail       <= 1'b1;
      end else begin
         if (addr_on_sys && (active || st_ff != mbx_pkg::LB_IDLE)) begin
            o_system_bus_pins <= active ? i_acc_addr[7:0] : addr_ff[7:0];
            o_system_bus_oe_n <= 1'b0;
         end else if (!i_chip_select_n && !i_register_select && i_host_dir
                      && !i_host_data_strobe_n) begin
            o_system_bus_pins <= host_acc ? out_head : o_system_bus_pins;
            o_system_bus_oe_n <= 1'b0;
         end else begin
            o_system_bus_oe_n <= 1'b1;
         end
         o_transfer_ack_n <= !(amr_ff[`AMR_ACK_BIT] && host_acc);
         o_bus_avail      <= !amr_ff[`AMR_BA_BIT] ? !addr_on_sys : 1'b1;
      end
   end
endmodule : host_mailbox_if

/* File: sim/host_mailbox_if_sva.sv */
/*
 Port checker for host_mailbox_if.
 Assumes a bind from the bench top; one clock, async high reset.
*/
module host_mailbox_if_sva (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_chip_select_n,
   input wire logic       i_register_select,
   input wire logic       i_host_dir,
   input wire logic       i_host_data_strobe_n,
   input wire logic       i_setup_instruction,
   input wire logic       i_give_mailbox,
   input wire logic       i_real_mode,
   input wire logic       o_handshake_n,
   input wire logic       o_mailbox_owner_flag,
   input wire logic       o_bus_avail,
   input wire logic [6:0] o_access_mode_reg,
   input wire logic       o_local_data_strobe_n,
   input wire logic       o_local_rd_n,
   input wire logic       o_local_wr_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------
   // Helpers and properties
   // ---------------------------------
   logic stb_ff;
   logic take;
   logic give;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Strobe history turns a held strobe into one qualified access
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stb_ff <= 1'b1;
      end else begin
         stb_ff <= i_host_data_strobe_n;
      end
   end
   assign take = stb_ff && !i_host_data_strobe_n && !i_chip_select_n;
   assign give = i_setup_instruction && i_give_mailbox;
   property p_hs_set;
      give |=> !o_handshake_n;
   endproperty
   a_hs_set: assert property (p_hs_set) else $error("handshake not low on handover");
   property p_flag_src;
      $rose(o_mailbox_owner_flag) |-> $past(give, 2);
   endproperty
   a_flag_src: assert property (p_flag_src) else $error("owner flag set without handover");
   property p_req_hs;
      take && !i_register_select && i_host_dir |=> ##[0:1] o_handshake_n;
   endproperty
   a_req_hs: assert property (p_req_hs) else $error("handshake not released on request");
   property p_release;
      take && i_register_select |-> ##[1:3] !o_mailbox_owner_flag;
   endproperty
   a_release: assert property (p_release) else $error("owner flag not cleared");
   property p_slave_ba;
      !o_access_mode_reg[1] |-> o_bus_avail;
   endproperty
   a_slave_ba: assert property (p_slave_ba) else $error("bus busy in slave mode");
   property p_ds_mode;
      !o_local_data_strobe_n |-> o_access_mode_reg[3];
   endproperty
   a_ds_mode: assert property (p_ds_mode) else $error("data strobe in pulse mode");
   property p_pulse_mode;
      !(o_local_rd_n && o_local_wr_n) |-> !o_access_mode_reg[3] && (o_local_rd_n || o_local_wr_n);
   endproperty
   a_pulse_mode: assert property (p_pulse_mode) else $error("bad read or write pulse");
   property p_fast;
      $fell(o_local_data_strobe_n) && !o_access_mode_reg[0] |=> o_local_data_strobe_n;
   endproperty
   a_fast: assert property (p_fast) else $error("fast strobe not one cycle");
   property p_slow;
      $fell(o_local_data_strobe_n) && o_access_mode_reg[0] && i_real_mode
         |=> !o_local_data_strobe_n ##1 o_local_data_strobe_n;
   endproperty
   a_slow: assert property (p_slow) else $error("slow strobe not two cycles");
   c_req: cover property (take && !i_register_select && i_host_dir);
   c_give: cover property ($fell(o_handshake_n));
   c_slow: cover property ($fell(o_local_data_strobe_n) && o_access_mode_reg[0]);
endmodule : host_mailbox_if_sva

/* File: sim/host_model.sv */
/*
 Host processor on the system bus: strobe-style mailbox accesses.
 Assumes the bench clock; drives at falling edges.
*/
module host_model (
   input  wire logic       i_clk,
   output logic            o_cs_n,
   output logic            o_rs,
   output logic            o_dir,
   output logic            o_ds_n,
   output logic      [7:0] o_data,
   input  wire logic [7:0] i_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_cs_n = 1'b1;
      o_rs = 1'b0;
      o_dir = 1'b1;
      o_ds_n = 1'b1;
      o_data = 8'h00;
   end
   // One access per strobe fall; selects act as two address lines
   task automatic xfer(input logic rs, input logic dir, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge i_clk);
      o_cs_n = 1'b0;
      o_rs = rs;
      o_dir = dir;
      o_data = dir ? ~o_data : d;
      o_ds_n = 1'b0;
      repeat (2) @(negedge i_clk);
      q = i_data;
      o_cs_n = 1'b1;
      o_ds_n = 1'b1;
      o_data = ~o_data;
   endtask : xfer
endmodule : host_model

/* File: sim/tb_host_mailbox_if.sv */
/*
 Bench for host_mailbox_if: mailbox handover and local bus modes.
 Assumes host_model and the bound checker.
*/
module tb_host_mailbox_if;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_clk, i_rst, i_chip_select_n, i_register_select, i_host_dir;
   logic        i_host_data_strobe_n, i_setup_instruction, i_save_instruction;
   logic        i_give_mailbox, i_real_mode, i_instr_done, i_mbx_rd, i_mbx_wr;
   logic        i_acc_req, i_acc_wr, i_rd_ready, o_handshake_n, o_mailbox_owner_flag;
   logic        o_rd_valid, o_local_data_strobe_n, o_local_rw, o_local_rd_n;
   logic [7:0]  i_system_bus_pins, o_system_bus_pins, o_lbus_upper_byte;
   logic [7:0]  i_result_bus_upper_byte, q;
   logic [6:0]  i_amr_data, o_access_mode_reg;
   logic [11:0] i_acc_addr;
   logic [15:0] i_acc_wdata, o_rd_data, i_local_data_pins;
   int          n_mismatch, compares;
   const logic [7:0] dtoh[3] = '{8'h3a, 8'hc5, 8'h7e};
   const logic [7:0] htod[3] = '{8'h96, 8'h0f, 8'he1};
   const logic [6:0] modes[3] = '{7'h04, 7'h0c, 7'h0d};
   host_model hm (.i_clk(i_clk), .o_cs_n(i_chip_select_n), .o_rs(i_register_select),
      .o_dir(i_host_dir), .o_ds_n(i_host_data_strobe_n), .o_data(i_system_bus_pins),
      .i_data(o_system_bus_pins));
   host_mailbox_if dut (.i_clk, .i_rst, .i_chip_select_n, .i_register_select, .i_host_dir,
      .i_host_data_strobe_n, .i_system_bus_pins, .o_system_bus_pins,
      .o_system_bus_oe_n(), .o_handshake_n, .o_transfer_ack_n(), .o_bus_avail(),
      .i_setup_instruction, .i_save_instruction, .i_amr_data, .i_give_mailbox,
      .i_real_mode, .i_instr_done, .o_access_mode_reg, .o_mailbox_owner_flag,
      .o_core_halt(), .o_repeat_instr(), .i_mbx_rd, .o_lbus_upper_byte, .i_mbx_wr,
      .i_result_bus_upper_byte, .i_acc_req, .i_acc_wr, .i_acc_addr, .i_acc_wdata,
      .o_acc_busy(), .o_rd_valid, .o_rd_data, .i_rd_ready, .o_local_addr_pins(),
      .o_local_data_pins(), .o_local_data_oe_n(), .i_local_data_pins,
      .o_local_data_strobe_n, .o_local_rw, .o_local_rd_n, .o_local_wr_n());
   // Local device answers only while read; otherwise the bus shows a changed pattern
   assign i_local_data_pins = (!o_local_rd_n || (!o_local_data_strobe_n && o_local_rw))
                              ? {4'h5, i_acc_addr} : {4'ha, ~i_acc_addr};
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (e !== s) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic pulse(ref logic s);
      @(negedge i_clk);
      s = 1'b1;
      @(negedge i_clk);
      s = 1'b0;
   endtask : pulse
   // Address held after the request so the device model can answer it
   task automatic lacc(input logic wr, input logic [11:0] a);
      i_acc_req = 1'b1;
      i_acc_wr = wr;
      i_acc_addr = a;
      @(negedge i_clk);
      i_acc_req = 1'b0;
      repeat (5) @(negedge i_clk);
   endtask : lacc
   task automatic drain(input logic [15:0] e);
      int n;
      n = 0;
      while (o_rd_valid !== 1'b1 && n < 10) begin
         @(negedge i_clk);
         n++;
      end
      chk("rd_data", e, o_rd_data);
      i_rd_ready = 1'b1;
      @(negedge i_clk);
      i_rd_ready = 1'b0;
   endtask : drain
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (3000) @(posedge i_clk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      {i_setup_instruction, i_save_instruction, i_give_mailbox, i_mbx_rd, i_mbx_wr} = '0;
      {i_acc_req, i_acc_wr, i_rd_ready, i_amr_data, i_result_bus_upper_byte} = '0;
      i_acc_addr = 12'h000;
      i_acc_wdata = 16'h9b6d;
      i_real_mode = 1'b1;
      i_instr_done = 1'b1;
      i_rst = 1'b1;
      repeat (8) @(negedge i_clk);
      i_rst = 1'b0;
      @(negedge i_clk);
      chk("handshake_n", 1'b1, o_handshake_n);
      chk("owner", 1'b0, o_mailbox_owner_flag);
      chk("amr", 7'h04, o_access_mode_reg);
      for (int i = 0; i < 3; i++) begin
         i_result_bus_upper_byte = dtoh[i];
         pulse(i_mbx_wr);
      end
      i_amr_data = 7'h04;
      i_give_mailbox = 1'b1;
      pulse(i_setup_instruction);
      i_give_mailbox = 1'b0;
      chk("handshake_n", 1'b0, o_handshake_n);
      @(negedge i_clk);
      chk("owner", 1'b1, o_mailbox_owner_flag);
      for (int i = 0; i < 3; i++) begin
         hm.xfer(1'b0, 1'b1, 8'h00, q);
         chk("dsp_to_host", dtoh[i], q);
         chk("handshake_n", 1'b1, o_handshake_n);
      end
      for (int i = 0; i < 3; i++) begin
         hm.xfer(1'b0, 1'b0, htod[i], q);
      end
      hm.xfer(1'b1, 1'b0, 8'h00, q);
      repeat (2) @(negedge i_clk);
      chk("owner", 1'b0, o_mailbox_owner_flag);
      for (int i = 0; i < 3; i++) begin
         repeat (2) @(negedge i_clk);
         chk("host_to_dsp", htod[i], o_lbus_upper_byte);
         pulse(i_mbx_rd);
      end
      foreach (modes[m]) begin
         i_amr_data = modes[m];
         pulse(i_save_instruction);
         @(negedge i_clk);
         chk("amr", modes[m], o_access_mode_reg);
         lacc(1'b1, 12'h003);
         lacc(1'b0, 12'h021);
         lacc(1'b0, 12'h042);
         drain({4'h5, 12'h021});
         drain({4'h5, 12'h042});
      end
      finish_test();
   end
endmodule : tb_host_mailbox_if
bind host_mailbox_if host_mailbox_if_sva chk (.*);
